// File: logic/rfdi_regs.sv
// interrupt status, mask and sense registers for buck ramps and linear regulator faults
// Operation
// - buck2/3 high-side sense, held per switching cycle
// - ramp end sets buck1/2 done status
// - status sticky, cleared by read or write-one
// - ramp done masks reset set, read-write
// - ramp in-progress sense bits, read-only
// - linear regulator limit entry sets sticky status
// - linear limit masks reset set, read-write
// - linear limit sense follows live fault
// - unmasked set status pulls interrupt low
// - masked status never pulls interrupt low
`timescale 1ns/100ps
module rfdi_regs (
   // clock and reset
   input  wire logic                               clk,
   input  wire logic                               reset_n,
   // register port from the serial interface engine
   input  wire logic [rfdi_pkg::ADDR_W-1:0]        reg_addr,
   input  wire logic [rfdi_pkg::DATA_W-1:0]        reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic      [rfdi_pkg::DATA_W-1:0]        reg_rdata,
   // regulator status from the analog side
   input  wire logic                               sw_cycle_tick,
   input  wire logic                               buck2_high_limit_raw,
   input  wire logic                               buck3_high_limit_raw,
   input  wire logic [rfdi_pkg::NUM_BUCK_RAMP-1:0] voltage_ramp_busy,
   input  wire logic [rfdi_pkg::NUM_LIN-1:0]       lin_limit_raw,
   // open-drain interrupt pin toward the host
   output logic                                    irq_out_n_out,
   output logic                                    irq_out_n_oe_n
);
   import rfdi_pkg::*;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // a field zero-extended to a register byte, so unused bits read zero
   function automatic logic [DATA_W-1:0] pad_ramp(input logic [NUM_BUCK_RAMP-1:0] f);
      pad_ramp = {{(DATA_W-NUM_BUCK_RAMP){1'b0}}, f};
   endfunction

   function automatic logic [DATA_W-1:0] pad_lin(input logic [NUM_LIN-1:0] f);
      pad_lin = {{(DATA_W-NUM_LIN){1'b0}}, f};
   endfunction

   // buck1 high-side bit is owned elsewhere, so the field sits one place up
   function automatic logic [DATA_W-1:0] pad_hs(input logic [NUM_HS-1:0] f);
      pad_hs = {{(DATA_W-NUM_HS-HS_LSB){1'b0}}, f, {HS_LSB{1'b0}}};
   endfunction

   // a read clears the whole bank, a write only the bits written as one
   function automatic logic [DATA_W-1:0] clr_vec(input logic              hit,
                                                 input logic              rd,
                                                 input logic              wr,
                                                 input logic [DATA_W-1:0] d);
      clr_vec = {DATA_W{hit & rd}} | ({DATA_W{hit & wr}} & d);
   endfunction

   // a mask byte takes the written value, or keeps its own
   function automatic logic [DATA_W-1:0] mask_vec(input logic              hit,
                                                  input logic              wr,
                                                  input logic [DATA_W-1:0] d,
                                                  input logic [DATA_W-1:0] cur);
      mask_vec = (hit & wr) ? d : cur;
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [NUM_HS-1:0]        hs_sense_ff;
   logic [NUM_BUCK_RAMP-1:0] ramp_active_ff;
   logic [NUM_BUCK_RAMP-1:0] ramp_done_ff;
   logic [NUM_BUCK_RAMP-1:0] ramp_mask_ff;
   logic [NUM_LIN-1:0]       lin_sense_ff;
   logic [NUM_LIN-1:0]       lin_flag_ff;
   logic [NUM_LIN-1:0]       lin_mask_ff;
   logic [DATA_W-1:0]        rdata_ff;

   logic [NUM_HS-1:0]        nxt_hs_sense;
   logic [NUM_BUCK_RAMP-1:0] nxt_ramp_done;
   logic [NUM_BUCK_RAMP-1:0] nxt_ramp_mask;
   logic [NUM_LIN-1:0]       nxt_lin_flag;
   logic [NUM_LIN-1:0]       nxt_lin_mask;
   logic [DATA_W-1:0]        nxt_rdata;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   wire hit_hs      = (reg_addr == HIGH_SIDE_LIMIT_SENSE_ADDR);
   wire hit_rstat   = (reg_addr == DVS_DONE_STATUS_ADDR);
   wire hit_rmask   = (reg_addr == DVS_DONE_MASK_ADDR);
   wire hit_rsense  = (reg_addr == DVS_PROGRESS_SENSE_ADDR);
   wire hit_lstat   = (reg_addr == LINEAR_FAULT_STATUS_ADDR);
   wire hit_lmask   = (reg_addr == LINEAR_FAULT_MASK_ADDR);
   wire hit_lsense  = (reg_addr == LINEAR_FAULT_SENSE_ADDR);

   // ------------------------------------------------------------------
   // named fields
   // ------------------------------------------------------------------
   wire buck2_high_limit_sense = hs_sense_ff[HS_BUCK2_IDX];
   wire buck3_high_limit_sense = hs_sense_ff[HS_BUCK3_IDX];
   wire buck1_ramp_done_flag   = ramp_done_ff[BUCK1_IDX];
   wire buck2_ramp_done_flag   = ramp_done_ff[BUCK2_IDX];
   wire buck1_ramp_done_mask   = ramp_mask_ff[BUCK1_IDX];
   wire buck2_ramp_done_mask   = ramp_mask_ff[BUCK2_IDX];
   wire buck1_ramp_active      = ramp_active_ff[BUCK1_IDX];
   wire buck2_ramp_active      = ramp_active_ff[BUCK2_IDX];
   wire lin1_limit_flag        = lin_flag_ff[LIN1_IDX];
   wire lin2_limit_flag        = lin_flag_ff[LIN2_IDX];
   wire lin3_limit_flag        = lin_flag_ff[LIN3_IDX];
   wire lin1_limit_mask        = lin_mask_ff[LIN1_IDX];
   wire lin2_limit_mask        = lin_mask_ff[LIN2_IDX];
   wire lin3_limit_mask        = lin_mask_ff[LIN3_IDX];
   wire lin1_limit_sense       = lin_sense_ff[LIN1_IDX];
   wire lin2_limit_sense       = lin_sense_ff[LIN2_IDX];
   wire lin3_limit_sense       = lin_sense_ff[LIN3_IDX];

   // ------------------------------------------------------------------
   // events and clears
   // ------------------------------------------------------------------
   // a ramp is complete on the falling edge of its busy level
   wire [NUM_BUCK_RAMP-1:0] ramp_end  = ramp_active_ff & ~voltage_ramp_busy;
   // entering current limit is the rising edge of the live fault
   wire [NUM_LIN-1:0]       lin_enter = lin_limit_raw & ~lin_sense_ff;

   // ------------------------------------------------------------------
   // clears
   // ------------------------------------------------------------------
   wire [DATA_W-1:0]        ramp_clr_byte = clr_vec(hit_rstat, reg_rd, reg_wr, reg_wdata);
   wire [DATA_W-1:0]        lin_clr_byte  = clr_vec(hit_lstat, reg_rd, reg_wr, reg_wdata);
   wire [NUM_BUCK_RAMP-1:0] ramp_clr      = ramp_clr_byte[NUM_BUCK_RAMP-1:0];
   wire [NUM_LIN-1:0]       lin_clr       = lin_clr_byte[NUM_LIN-1:0];

   // set wins over a clear in the same cycle so no event is lost
   assign nxt_ramp_done = (ramp_done_ff & ~ramp_clr) | ramp_end;
   assign nxt_lin_flag  = (lin_flag_ff & ~lin_clr) | lin_enter;

   wire [DATA_W-1:0] ramp_mask_byte = mask_vec(hit_rmask, reg_wr, reg_wdata,
                                               pad_ramp(ramp_mask_ff));
   wire [DATA_W-1:0] lin_mask_byte  = mask_vec(hit_lmask, reg_wr, reg_wdata,
                                               pad_lin(lin_mask_ff));
   // bits above the field are dropped here, so writes to them are ignored
   assign nxt_ramp_mask = ramp_mask_byte[NUM_BUCK_RAMP-1:0];
   assign nxt_lin_mask  = lin_mask_byte[NUM_LIN-1:0];

   // high-side sense updates only once per switching cycle, so it cannot chatter
   assign nxt_hs_sense  = sw_cycle_tick ?
                          {buck3_high_limit_raw, buck2_high_limit_raw} : hs_sense_ff;

   // ------------------------------------------------------------------
   // read mux; unused bits and unmapped addresses read zero
   // ------------------------------------------------------------------
   wire [DATA_W-1:0] rd_hs     = pad_hs({buck3_high_limit_sense, buck2_high_limit_sense});
   wire [DATA_W-1:0] rd_rstat  = pad_ramp({buck2_ramp_done_flag, buck1_ramp_done_flag});
   wire [DATA_W-1:0] rd_rmask  = pad_ramp({buck2_ramp_done_mask, buck1_ramp_done_mask});
   wire [DATA_W-1:0] rd_rsense = pad_ramp({buck2_ramp_active, buck1_ramp_active});
   wire [DATA_W-1:0] rd_lstat  =
      pad_lin({lin3_limit_flag, lin2_limit_flag, lin1_limit_flag});
   wire [DATA_W-1:0] rd_lmask  =
      pad_lin({lin3_limit_mask, lin2_limit_mask, lin1_limit_mask});
   wire [DATA_W-1:0] rd_lsense =
      pad_lin({lin3_limit_sense, lin2_limit_sense, lin1_limit_sense});

   wire [DATA_W-1:0] rd_sel =
      ({DATA_W{hit_hs}}     & rd_hs)     |
      ({DATA_W{hit_rstat}}  & rd_rstat)  |
      ({DATA_W{hit_rmask}}  & rd_rmask)  |
      ({DATA_W{hit_rsense}} & rd_rsense) |
      ({DATA_W{hit_lstat}}  & rd_lstat)  |
      ({DATA_W{hit_lmask}}  & rd_lmask)  |
      ({DATA_W{hit_lsense}} & rd_lsense);

   // status value captured before the read clears it
   assign nxt_rdata = reg_rd ? rd_sel : rdata_ff;

   // ------------------------------------------------------------------
   // interrupt pin
   // ------------------------------------------------------------------
   // one pending term per source keeps the mask pairing obvious
   wire buck1_ramp_irq = buck1_ramp_done_flag & ~buck1_ramp_done_mask;
   wire buck2_ramp_irq = buck2_ramp_done_flag & ~buck2_ramp_done_mask;
   wire lin1_limit_irq = lin1_limit_flag & ~lin1_limit_mask;
   wire lin2_limit_irq = lin2_limit_flag & ~lin2_limit_mask;
   wire lin3_limit_irq = lin3_limit_flag & ~lin3_limit_mask;

   // ------------------------------------------------------------------
   // bank merge
   // ------------------------------------------------------------------
   wire ramp_bank_irq  = buck1_ramp_irq | buck2_ramp_irq;
   wire lin_bank_irq   = lin1_limit_irq | lin2_limit_irq | lin3_limit_irq;
   // other banks of the device are merged outside this block
   wire irq_pend       = ramp_bank_irq | lin_bank_irq;

   assign irq_out_n_out  = 1'b0;
   assign irq_out_n_oe_n = ~irq_pend;
   assign reg_rdata      = rdata_ff;

   // ------------------------------------------------------------------
   // sense registers
   // ------------------------------------------------------------------
   // high-side sense holds between switching ticks
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hs_sense_ff <= HS_ZERO;
      end else begin
         hs_sense_ff <= nxt_hs_sense;
      end
   end

   // the delayed copy is also the edge reference for ramp end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ramp_active_ff <= RAMP_ZERO;
      end else begin
         ramp_active_ff <= voltage_ramp_busy;
      end
   end

   // the delayed copy is also the edge reference for limit entry
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lin_sense_ff <= LIN_ZERO;
      end else begin
         lin_sense_ff <= lin_limit_raw;
      end
   end

   // ------------------------------------------------------------------
   // sticky status
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ramp_done_ff <= RAMP_ZERO;
      end else begin
         ramp_done_ff <= nxt_ramp_done;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lin_flag_ff <= LIN_ZERO;
      end else begin
         lin_flag_ff <= nxt_lin_flag;
      end
   end

   // ------------------------------------------------------------------
   // masks
   // ------------------------------------------------------------------
   // masked after reset so nothing fires before software is ready
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ramp_mask_ff <= RAMP_MASK_RST;
      end else begin
         ramp_mask_ff <= nxt_ramp_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lin_mask_ff <= LIN_MASK_RST;
      end else begin
         lin_mask_ff <= nxt_lin_mask;
      end
   end

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   // holds the pre-clear value until the next read strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_ff <= DATA_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

endmodule

// File: logic/rfdi_pkg.sv
// register map and field constants for the regulator fault and ramp interrupt block
package rfdi_pkg;

   // ------------------------------------------------------------------
   // register bus shape
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] HIGH_SIDE_LIMIT_SENSE_ADDR = 8'h0d;
   localparam logic [ADDR_W-1:0] DVS_DONE_STATUS_ADDR       = 8'h0e;
   localparam logic [ADDR_W-1:0] DVS_DONE_MASK_ADDR         = 8'h0f;
   localparam logic [ADDR_W-1:0] DVS_PROGRESS_SENSE_ADDR    = 8'h10;
   localparam logic [ADDR_W-1:0] LINEAR_FAULT_STATUS_ADDR   = 8'h18;
   localparam logic [ADDR_W-1:0] LINEAR_FAULT_MASK_ADDR     = 8'h19;
   localparam logic [ADDR_W-1:0] LINEAR_FAULT_SENSE_ADDR    = 8'h1a;

   // ------------------------------------------------------------------
   // field layouts
   // ------------------------------------------------------------------
   localparam int NUM_BUCK_RAMP = 2;
   localparam int NUM_LIN       = 3;
   localparam int NUM_HS        = 2;
   localparam int HS_LSB        = 1;

   // bit positions inside the packed field vectors
   localparam int BUCK1_IDX     = 0;
   localparam int BUCK2_IDX     = 1;
   localparam int LIN1_IDX      = 0;
   localparam int LIN2_IDX      = 1;
   localparam int LIN3_IDX      = 2;
   localparam int HS_BUCK2_IDX  = 0;
   localparam int HS_BUCK3_IDX  = 1;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [NUM_BUCK_RAMP-1:0] RAMP_MASK_RST   = 2'h3;
   localparam logic [NUM_LIN-1:0]       LIN_MASK_RST    = 3'h7;
   localparam logic [NUM_BUCK_RAMP-1:0] RAMP_ZERO       = 2'h0;
   localparam logic [NUM_LIN-1:0]       LIN_ZERO        = 3'h0;
   localparam logic [NUM_HS-1:0]        HS_ZERO         = 2'h0;
   localparam logic [DATA_W-1:0]        DATA_ZERO       = 8'h00;

endpackage

// File: bench/rfdi_regs_asserts.sv
// port checks for the interrupt status, mask and sense block
`timescale 1ns/100ps
module rfdi_regs_asserts
   import rfdi_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       sw_cycle_tick,
   input wire logic       buck2_high_limit_raw,
   input wire logic       buck3_high_limit_raw,
   input wire logic [1:0] voltage_ramp_busy,
   input wire logic [2:0] lin_limit_raw,
   input wire logic       irq_out_n_out,
   input wire logic       irq_out_n_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire rd_ls = reg_rd && reg_addr == LINEAR_FAULT_STATUS_ADDR;
   wire rd_hs = reg_rd && reg_addr == HIGH_SIDE_LIMIT_SENSE_ADDR;
   a_irq_data_low: assert property (irq_out_n_out == 1'b0) else $error("irq data not low");
   a_lin_sense: assert property (reg_rd && reg_addr == LINEAR_FAULT_SENSE_ADDR && $past(reset_n)
      && $stable(lin_limit_raw) |=> reg_rdata == {5'h0, $past(lin_limit_raw)})
      else $error("linear sense wrong");
   a_ramp_sense: assert property (reg_rd && reg_addr == DVS_PROGRESS_SENSE_ADDR && $past(reset_n)
      && $stable(voltage_ramp_busy) |=> reg_rdata == {6'h0, $past(voltage_ramp_busy)})
      else $error("ramp sense wrong");
   a_read_clears: assert property ((rd_ls && lin_limit_raw == 3'h0)[*2] |=> reg_rdata == 8'h00)
      else $error("status not cleared by read");
   a_hs_hold: assert property (rd_hs && !sw_cycle_tick ##1 rd_hs |=> $stable(reg_rdata))
      else $error("high side sense moved");
   a_hs_field: assert property (rd_hs |=> (reg_rdata & 8'hf9) == 8'h00)
      else $error("high side unused bits");
   a_mask_wr: assert property (reg_wr && reg_addr == LINEAR_FAULT_MASK_ADDR ##1 reg_rd
      && reg_addr == LINEAR_FAULT_MASK_ADDR |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07))
      else $error("mask readback wrong");
   a_ramp_done: assert property ($fell(voltage_ramp_busy[0]) && $past(reset_n) ##1 reg_rd
      && reg_addr == DVS_DONE_STATUS_ADDR |=> reg_rdata[0]) else $error("ramp done missing");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
   c_irq: cover property ($fell(irq_out_n_oe_n));
   c_clear: cover property (rd_ls ##1 rd_ls);
   c_hs: cover property (rd_hs ##1 rd_hs);
endmodule

// File: bench/rfdi_host_line.sv
// host view of the open-drain interrupt line with its pull-up
`timescale 1ns/100ps
module rfdi_host_line (
   input  wire logic oe_n,
   input  wire logic pin_out,
   output logic      irq_level
);
   assign irq_level = oe_n ? 1'b1 : pin_out;
endmodule

// File: bench/rfdi_regs_tb_top.sv
// self-checking bench for the interrupt register block
`timescale 1ns/100ps
module rfdi_regs_tb_top;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sw_cycle_tick = 1'b0;
   logic buck2_high_limit_raw = 1'b0, buck3_high_limit_raw = 1'b0, oe_n, pin_out, irq_level;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [1:0] voltage_ramp_busy = 2'h0;
   logic [2:0] lin_limit_raw = 3'h0;
   logic [7:0] ra[8] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h18, 8'h19, 8'h1a, 8'h30};
   logic [7:0] re[8] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
   int n_errors = 0, n_tests = 0, cycles = 0;
   rfdi_regs dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sw_cycle_tick, .buck2_high_limit_raw, .buck3_high_limit_raw, .voltage_ramp_busy,
      .lin_limit_raw, .irq_out_n_out(pin_out), .irq_out_n_oe_n(oe_n));
   rfdi_host_line u_host (.oe_n, .pin_out, .irq_level);
   always #2.5 clk = ~clk;
   task close_out;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         close_out;
      end
   end
   task ck(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // one access per cycle, strobes stay up so calls run back to back
   task acc(input logic w, input logic [7:0] a, d, e);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      if (!w) ck("rdata", e, reg_rdata);
   endtask
   task idl(input int n);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (n) @(negedge clk);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      for (int i = 0; i < 8; i++) acc(1'b0, ra[i], 8'h00, re[i]);
      acc(1'b1, 8'h1a, 8'hff, 8'h00);
      acc(1'b1, 8'h30, 8'hff, 8'h00);
      acc(1'b0, 8'h1a, 8'h00, 8'h00);
      acc(1'b0, 8'h30, 8'h00, 8'h00);
      lin_limit_raw = 3'h5;
      idl(2);
      ck("irq", 8'h01, {7'h0, irq_level});
      acc(1'b0, 8'h1a, 8'h00, 8'h05);
      acc(1'b0, 8'h18, 8'h00, 8'h05);
      acc(1'b0, 8'h18, 8'h00, 8'h00);
      lin_limit_raw = 3'h0;
      idl(2);
      acc(1'b0, 8'h18, 8'h00, 8'h00);
      acc(1'b0, 8'h18, 8'h00, 8'h00);
      lin_limit_raw = 3'h2;
      idl(2);
      acc(1'b1, 8'h19, 8'hfd, 8'h00);
      acc(1'b0, 8'h19, 8'h00, 8'h05);
      ck("irq", 8'h00, {7'h0, irq_level});
      acc(1'b1, 8'h18, 8'h02, 8'h00);
      ck("irq", 8'h01, {7'h0, irq_level});
      voltage_ramp_busy = 2'h3;
      idl(2);
      acc(1'b0, 8'h10, 8'h00, 8'h03);
      voltage_ramp_busy = 2'h0;
      idl(1);
      acc(1'b0, 8'h0e, 8'h00, 8'h03);
      voltage_ramp_busy = 2'h1;
      idl(2);
      voltage_ramp_busy = 2'h0;
      idl(2);
      ck("irq", 8'h01, {7'h0, irq_level});
      acc(1'b1, 8'h0f, 8'hfe, 8'h00);
      ck("irq", 8'h00, {7'h0, irq_level});
      acc(1'b0, 8'h0f, 8'h00, 8'h02);
      acc(1'b1, 8'h0e, 8'h01, 8'h00);
      ck("irq", 8'h01, {7'h0, irq_level});
      buck2_high_limit_raw = 1'b1;
      idl(2);
      acc(1'b0, 8'h0d, 8'h00, 8'h00);
      sw_cycle_tick = 1'b1;
      idl(1);
      sw_cycle_tick = 1'b0;
      buck3_high_limit_raw = 1'b1;
      idl(2);
      acc(1'b0, 8'h0d, 8'h00, 8'h02);
      acc(1'b0, 8'h0d, 8'h00, 8'h02);
      sw_cycle_tick = 1'b1;
      idl(1);
      sw_cycle_tick = 1'b0;
      acc(1'b0, 8'h0d, 8'h00, 8'h06);
      idl(1);
      close_out;
   end
endmodule
bind rfdi_regs rfdi_regs_asserts u_chk (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .sw_cycle_tick, .buck2_high_limit_raw, .buck3_high_limit_raw,
   .voltage_ramp_busy, .lin_limit_raw, .irq_out_n_out, .irq_out_n_oe_n);
